/* common/spic_pkg.sv */
// package of constants for the switch port identification and command registers
`default_nettype none
package spic_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] SPIC_ID_OFFSET = 12'h000;
  localparam logic [11:0] SPIC_CMD_OFFSET = 12'h004;
  // ****************************************
  // command field positions
  // ****************************************
  localparam int SPIC_CMD_IO_BIT = 0;
  localparam int SPIC_CMD_MEM_BIT = 1;
  localparam int SPIC_CMD_BM_BIT = 2;
  localparam int SPIC_CMD_PERR_BIT = 6;
  localparam int SPIC_CMD_SERR_BIT = 8;
  localparam int SPIC_CMD_INTD_BIT = 10;
  // mask of writable command bits; the rest read as zero
  localparam logic [15:0] SPIC_CMD_WMASK = 16'h0547;
  localparam logic [15:0] SPIC_CMD_RESET = 16'h0000;
  // ****************************************
  // identifier defaults, values arbitrary
  // ****************************************
  localparam logic [15:0] SPIC_VENDOR_DEFAULT = 16'h1234; // arbitrary value
  localparam logic [15:0] SPIC_DEVICE_DEFAULT = 16'h5678; // arbitrary value
  // request kinds arriving at the gate
  typedef enum logic [1:0] {SPIC_REQ_MEM, SPIC_REQ_IO, SPIC_REQ_OTHER} spic_req_t;
endpackage : spic_pkg
`default_nettype wire

/* rtl/spic_req_gate.sv */
// request gating by command enables
`default_nettype none
module spic_req_gate (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] cmd,
  input wire spic_pkg::spic_req_t pri_kind,
  input wire logic pri_valid,
  output logic pri_accept,
  input wire spic_pkg::spic_req_t dn_kind,
  input wire logic dn_valid,
  input wire logic dn_nonposted,
  output logic dn_forward,
  output logic dn_ur,
  output logic ur_cpl
);
  import spic_pkg::*;
  // ****************************************
  // combinational gating and the registered completion request
  // ****************************************
  // memory or i/o request classifier, used three times
  function automatic logic is_memio(input spic_req_t k);
    return (k == SPIC_REQ_MEM) || (k == SPIC_REQ_IO);
  endfunction : is_memio
  wire logic pri_io_ok = (pri_kind == SPIC_REQ_IO) && cmd[SPIC_CMD_IO_BIT];
  wire logic pri_mem_ok = (pri_kind == SPIC_REQ_MEM) && cmd[SPIC_CMD_MEM_BIT];
  // other kinds are not governed by the space enables
  assign pri_accept = pri_valid && (pri_io_ok || pri_mem_ok || !is_memio(pri_kind));
  wire logic dn_memio = dn_valid && is_memio(dn_kind);
  assign dn_forward = dn_valid && (!is_memio(dn_kind) || cmd[SPIC_CMD_BM_BIT]);
  assign dn_ur = dn_memio && !cmd[SPIC_CMD_BM_BIT];
  // completion request registered: one pulse the cycle after a rejected non-posted
  always_ff @(posedge clk) begin
    if (srst) begin
      ur_cpl <= 1'b0;
    end else begin
      ur_cpl <= dn_ur && dn_nonposted;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  // a rejected non-posted request is always answered
  a_ur_cpl_follows: assert property (@(posedge clk) disable iff (srst)
    (dn_ur && dn_nonposted) |=> ur_cpl)
    else $error("ur completion missing");
  // posted or accepted requests never draw a completion
  a_ur_cpl_only: assert property (@(posedge clk) disable iff (srst)
    !(dn_ur && dn_nonposted) |=> !ur_cpl)
    else $error("spurious ur completion");
  // no memory or i/o request goes upstream while bus mastering is off
  a_no_fwd_disabled: assert property (@(posedge clk) disable iff (srst)
    (dn_memio && !cmd[SPIC_CMD_BM_BIT]) |-> !dn_forward)
    else $error("forwarded while bus master off");
  // memory and i/o are flagged unsupported while bus mastering is off
  a_ur_disabled: assert property (@(posedge clk) disable iff (srst)
    (dn_memio && !cmd[SPIC_CMD_BM_BIT]) |-> dn_ur)
    else $error("unsupported request not flagged");
endmodule : spic_req_gate
`default_nettype wire

/* rtl/spic_regs.sv */
// identification and command registers of a switch port configuration header
`default_nettype none
module spic_regs (
  input wire logic clk,
  input wire logic srst,
  // configuration access from the root complex
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  output logic [31:0] cfg_rdata,
  // identifier override from sideband bus or eeprom loader
  input wire logic id_load,
  input wire logic [15:0] id_vendor_in,
  input wire logic [15:0] id_device_in,
  // primary side requests
  input wire spic_pkg::spic_req_t pri_kind,
  input wire logic pri_valid,
  output logic pri_accept,
  // requests arriving at the downstream port
  input wire spic_pkg::spic_req_t dn_kind,
  input wire logic dn_valid,
  input wire logic dn_nonposted,
  output logic dn_forward,
  output logic dn_ur,
  output logic ur_cpl,
  // error and interrupt paths
  input wire logic parity_err,
  output logic parity_act,
  input wire logic err_event,
  output logic err_report,
  input wire logic own_int_req,
  output logic own_int_send,
  input wire logic fwd_int_req,
  output logic fwd_int_send
);
  import spic_pkg::*;
  // ****************************************
  // storage
  // ****************************************
  logic [15:0] vendor_identifier; // live vendor identifier
  logic [15:0] device_identifier; // live device identifier
  logic [15:0] port_command; // only writable bits ever hold ones
  // ****************************************
  // decode
  // ****************************************
  wire logic hit_id = (cfg_addr == SPIC_ID_OFFSET);
  wire logic hit_cmd = (cfg_addr == SPIC_CMD_OFFSET);
  // byte lanes merge into the writable bits only; read-only bits drop
  wire logic [15:0] lane_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
  wire logic [15:0] next_port_command =
    (port_command & ~lane_mask) | (cfg_wdata[15:0] & lane_mask & SPIC_CMD_WMASK);
  // identifier load: writes to the id dword never touch it
  always_ff @(posedge clk) begin
    if (srst) begin
      vendor_identifier <= SPIC_VENDOR_DEFAULT;
      device_identifier <= SPIC_DEVICE_DEFAULT;
    end else if (id_load) begin
      vendor_identifier <= id_vendor_in;
      device_identifier <= id_device_in;
    end
  end
  // command register write
  always_ff @(posedge clk) begin
    if (srst) begin
      port_command <= SPIC_CMD_RESET;
    end else if (cfg_wr && hit_cmd) begin
      port_command <= next_port_command;
    end
  end
  // legacy and reserved bits are zero by construction of the mask
  wire logic [31:0] id_word = {device_identifier, vendor_identifier};
  wire logic [31:0] cmd_word = {16'h0000, port_command & SPIC_CMD_WMASK};
  // unmapped offsets read zero rather than aliasing a live register
  wire logic [31:0] next_cfg_rdata =
    hit_id ? id_word : (hit_cmd ? cmd_word : 32'h00000000);
  // read data is registered and holds until the next read
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_rdata <= 32'h00000000;
    end else if (cfg_rd) begin
      cfg_rdata <= next_cfg_rdata;
    end
  end
  // ****************************************
  // enables applied to traffic
  // ****************************************
  // the gate module holds the request decode and the completion flop
  spic_req_gate u_gate (
    .clk(clk),
    .srst(srst),
    .cmd(port_command),
    .pri_kind(pri_kind),
    .pri_valid(pri_valid),
    .pri_accept(pri_accept),
    .dn_kind(dn_kind),
    .dn_valid(dn_valid),
    .dn_nonposted(dn_nonposted),
    .dn_forward(dn_forward),
    .dn_ur(dn_ur),
    .ur_cpl(ur_cpl)
  );
  // parity action only while parity response is enabled
  assign parity_act = parity_err && port_command[SPIC_CMD_PERR_BIT];
  // error messages only leave while reporting is enabled
  assign err_report = err_event && port_command[SPIC_CMD_SERR_BIT];
  // the disable bit silences only this port's own interrupts
  assign own_int_send = own_int_req && !port_command[SPIC_CMD_INTD_BIT];
  // forwarded interrupts pass whatever the disable bit says
  assign fwd_int_send = fwd_int_req;
  // ****************************************
  // elaboration checks
  // ****************************************
  // the read path trusts the write mask, so a mask that reached a legacy or
  // reserved bit would let that bit read back as one; refuse such a package
  if ((SPIC_CMD_WMASK & 16'hfab8) != 16'h0000) begin : g_mask_check
    $error("write mask reaches legacy or reserved command bits");
  end
  // the value after reset has to be storable in the writable bits
  if ((SPIC_CMD_RESET & ~SPIC_CMD_WMASK) != 16'h0000) begin : g_reset_check
    $error("command reset value outside the writable bits");
  end
  // ****************************************
  // checks
  // ****************************************
  // reset leaves every enable off
  a_cmd_reset_zero: assert property (@(posedge clk)
    srst |=> port_command == SPIC_CMD_RESET)
    else $error("command not cleared");
  // legacy and reserved bits never hold a one
  a_legacy_zero: assert property (@(posedge clk) disable iff (srst)
    (port_command & ~SPIC_CMD_WMASK) == 16'h0000)
    else $error("legacy bit set");
  // a write to the identifier dword changes nothing
  a_id_write_kept: assert property (@(posedge clk) disable iff (srst)
    (cfg_wr && hit_id && !id_load) |=> $stable(vendor_identifier) && $stable(device_identifier))
    else $error("identifier changed by write");
  // identifier read returns both halves as they stood
  a_id_read: assert property (@(posedge clk) disable iff (srst)
    (cfg_rd && hit_id) |=> cfg_rdata == {$past(device_identifier), $past(vendor_identifier)})
    else $error("identifier read wrong");
  // sideband or loader value replaces the vendor identifier
  a_id_load: assert property (@(posedge clk) disable iff (srst)
    id_load |=> vendor_identifier == $past(id_vendor_in))
    else $error("load lost");
  // and the device identifier alike
  a_id_load_dev: assert property (@(posedge clk) disable iff (srst)
    id_load |=> device_identifier == $past(id_device_in))
    else $error("device load lost");
  // i/o refused while its enable is off
  a_io_gate: assert property (@(posedge clk) disable iff (srst)
    (pri_valid && pri_kind == SPIC_REQ_IO && !port_command[SPIC_CMD_IO_BIT]) |-> !pri_accept)
    else $error("io answered while off");
  // and answered while it is on
  a_io_pass: assert property (@(posedge clk) disable iff (srst)
    (pri_valid && pri_kind == SPIC_REQ_IO && port_command[SPIC_CMD_IO_BIT]) |-> pri_accept)
    else $error("io refused while on");
  // memory answered exactly when its enable is on
  a_mem_gate: assert property (@(posedge clk) disable iff (srst)
    (pri_valid && pri_kind == SPIC_REQ_MEM) |-> pri_accept == port_command[SPIC_CMD_MEM_BIT])
    else $error("memory gate wrong");
  // bus mastering on: everything goes upstream
  a_fwd_on: assert property (@(posedge clk) disable iff (srst)
    (dn_valid && port_command[SPIC_CMD_BM_BIT]) |-> dn_forward && !dn_ur)
    else $error("not forwarded");
  // bus mastering off: memory and i/o are unsupported and never forwarded
  a_bm_off_ur: assert property (@(posedge clk) disable iff (srst)
    (dn_valid && dn_kind != SPIC_REQ_OTHER && !port_command[SPIC_CMD_BM_BIT])
    |-> dn_ur && !dn_forward)
    else $error("memory or io not refused");
  // parity action never taken while response is off
  a_perr_gate: assert property (@(posedge clk) disable iff (srst)
    parity_act |-> port_command[SPIC_CMD_PERR_BIT])
    else $error("parity act while off");
  // and always taken while it is on
  a_perr_pass: assert property (@(posedge clk) disable iff (srst)
    (parity_err && port_command[SPIC_CMD_PERR_BIT]) |-> parity_act)
    else $error("parity act missing");
  // no error report while reporting is off
  a_serr_gate: assert property (@(posedge clk) disable iff (srst)
    err_report |-> port_command[SPIC_CMD_SERR_BIT])
    else $error("error reported while off");
  // every error reported while it is on
  a_serr_pass: assert property (@(posedge clk) disable iff (srst)
    (err_event && port_command[SPIC_CMD_SERR_BIT]) |-> err_report)
    else $error("error report missing");
  // own interrupts silent while disabled
  a_int_gate: assert property (@(posedge clk) disable iff (srst)
    own_int_send |-> !port_command[SPIC_CMD_INTD_BIT])
    else $error("interrupt while disabled");
  // and sent while allowed
  a_int_pass: assert property (@(posedge clk) disable iff (srst)
    (own_int_req && !port_command[SPIC_CMD_INTD_BIT]) |-> own_int_send)
    else $error("interrupt lost while allowed");
  // forwarded interrupts never blocked
  a_fwd_int: assert property (@(posedge clk) disable iff (srst)
    fwd_int_req |-> fwd_int_send)
    else $error("forwarded interrupt blocked");
  // reserved bits stay zero after any command write
  a_rsvd_write: assert property (@(posedge clk) disable iff (srst)
    (cfg_wr && hit_cmd) |=> port_command[15:11] == 5'h00)
    else $error("reserved held");
  // a full write keeps only the writable bits
  a_cmd_write: assert property (@(posedge clk) disable iff (srst)
    (cfg_wr && hit_cmd && cfg_be[1:0] == 2'b11)
    |=> {16'h0000, port_command} == ($past(cfg_wdata) & {16'h0000, SPIC_CMD_WMASK}))
    else $error("command write wrong");
  // a disabled low lane keeps its bits
  a_cmd_lane_lo: assert property (@(posedge clk) disable iff (srst)
    (cfg_wr && hit_cmd && !cfg_be[0]) |=> $stable(port_command[7:0]))
    else $error("low command byte changed");
  // a disabled high lane keeps its bits
  a_cmd_lane_hi: assert property (@(posedge clk) disable iff (srst)
    (cfg_wr && hit_cmd && !cfg_be[1]) |=> $stable(port_command[15:8]))
    else $error("high command byte changed");
  // command read shows the stored enables with an empty upper half
  a_cmd_read: assert property (@(posedge clk) disable iff (srst)
    (cfg_rd && hit_cmd) |=> cfg_rdata == {16'h0000, $past(port_command)})
    else $error("command read wrong");
  // unmapped offsets read zero
  a_unmapped_zero: assert property (@(posedge clk) disable iff (srst)
    (cfg_rd && !hit_id && !hit_cmd) |=> cfg_rdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule : spic_regs
`default_nettype wire

/* verif/spic_rc_model.sv */
// root complex model issuing configuration reads and writes
`default_nettype none
module spic_rc_model (
  input wire logic clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [11:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  output logic [3:0] cfg_be,
  input wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero, so nothing is taken during reset
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 12'h000;
    cfg_wdata = 32'h0;
    cfg_be = 4'h0;
  end
  // one-cycle write pulse, launched off the falling edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    @(negedge clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = b;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d; // stale data scrambled, never left looking valid
  endtask : wr
  // read pulse; data is registered, so it is taken one edge later
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge clk);
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask : rd
endmodule : spic_rc_model
`default_nettype wire

/* verif/switch_port_id_command_regs_tb_top.sv */
// self-checking bench for the identification and command registers
`default_nettype none
module switch_port_id_command_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spic_pkg::*;
  logic clk, srst, cfg_wr, cfg_rd, id_load, pri_valid, dn_valid, dn_nonposted;
  logic parity_err, err_event, own_int_req, fwd_int_req, pri_accept, dn_forward, dn_ur;
  logic ur_cpl, parity_act, err_report, own_int_send, fwd_int_send;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, rd_val;
  logic [3:0] cfg_be;
  logic [15:0] id_vendor_in, id_device_in;
  spic_req_t pri_kind, dn_kind;
  int error_cnt = 0;
  int n_tests = 0;
  spic_regs i_spic_regs (.clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
    .id_load(id_load), .id_vendor_in(id_vendor_in), .id_device_in(id_device_in),
    .pri_kind(pri_kind), .pri_valid(pri_valid), .pri_accept(pri_accept), .dn_kind(dn_kind),
    .dn_valid(dn_valid), .dn_nonposted(dn_nonposted), .dn_forward(dn_forward), .dn_ur(dn_ur),
    .ur_cpl(ur_cpl), .parity_err(parity_err), .parity_act(parity_act), .err_event(err_event),
    .err_report(err_report), .own_int_req(own_int_req), .own_int_send(own_int_send),
    .fwd_int_req(fwd_int_req), .fwd_int_send(fwd_int_send));
  spic_rc_model i_spic_rc_model (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata));
  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // scenarios
  // ****************************************
  // reset values, then writes to read-only and reserved places and a read of an unmapped place
  task automatic t_regs();
    i_spic_rc_model.rd(SPIC_CMD_OFFSET, rd_val);
    chk(rd_val, 32'h0);
    i_spic_rc_model.wr(SPIC_ID_OFFSET, 32'hffffffff, 4'hf);
    i_spic_rc_model.rd(SPIC_ID_OFFSET, rd_val);
    chk(rd_val, {SPIC_DEVICE_DEFAULT, SPIC_VENDOR_DEFAULT});
    i_spic_rc_model.wr(SPIC_CMD_OFFSET, 32'hffffffff, 4'hf);
    i_spic_rc_model.rd(SPIC_CMD_OFFSET, rd_val);
    chk(rd_val, 32'h00000547);
    // each byte lane alone leaves the other lane untouched
    i_spic_rc_model.wr(SPIC_CMD_OFFSET, 32'h0, 4'h1);
    i_spic_rc_model.rd(SPIC_CMD_OFFSET, rd_val);
    chk(rd_val, 32'h00000500);
    i_spic_rc_model.wr(SPIC_CMD_OFFSET, 32'h0, 4'h2);
    i_spic_rc_model.rd(SPIC_CMD_OFFSET, rd_val);
    chk(rd_val, 32'h00000000);
    i_spic_rc_model.rd(12'h008, rd_val);
    chk(rd_val, 32'h0);
    @(negedge clk);
    {id_vendor_in, id_device_in, id_load} = {16'hbeef, 16'hcafe, 1'b1};
    @(negedge clk);
    id_load = 1'b0;
    i_spic_rc_model.rd(SPIC_ID_OFFSET, rd_val);
    chk(rd_val, 32'hcafebeef);
    $display("test regs done");
  endtask : t_regs
  // traffic gates for one command value: memory, i/o, then a kind no enable governs
  task automatic t_gates(input logic [15:0] c);
    logic memio;
    i_spic_rc_model.wr(SPIC_CMD_OFFSET, {16'h0, c}, 4'h3);
    for (int k = 0; k < 3; k++) begin
      memio = (k != 2);
      @(negedge clk);
      pri_kind = spic_req_t'(k);
      dn_kind = spic_req_t'(k);
      {pri_valid, dn_valid} = 2'b11;
      // i/o goes posted, so a rejected posted request must draw no completion
      dn_nonposted = (k != 1);
      {parity_err, err_event, own_int_req, fwd_int_req} = 4'hf;
      #1;
      chk(pri_accept, (k == 0) ? c[1] : ((k == 1) ? c[0] : 1'b1));
      chk({dn_forward, dn_ur}, {c[2] || !memio, !c[2] && memio});
      chk({parity_act, err_report}, {c[6], c[8]});
      chk({own_int_send, fwd_int_send}, {!c[10], 1'b1});
      @(negedge clk);
      chk(ur_cpl, !c[2] && (k == 0));
    end
    {pri_valid, dn_valid, parity_err, err_event, own_int_req, fwd_int_req} = 6'h0;
    #1;
    chk({pri_accept, dn_forward, dn_ur}, 3'h0);
    chk({parity_act, err_report, own_int_send, fwd_int_send}, 4'h0);
    $display("test gates %h done", c);
  endtask : t_gates
  // reset in mid-run clears the enables and restores the identifier defaults
  task automatic t_reset();
    @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    i_spic_rc_model.rd(SPIC_CMD_OFFSET, rd_val);
    chk(rd_val, {16'h0000, SPIC_CMD_RESET});
    i_spic_rc_model.rd(SPIC_ID_OFFSET, rd_val);
    chk(rd_val, {SPIC_DEVICE_DEFAULT, SPIC_VENDOR_DEFAULT});
    $display("test reset done");
  endtask : t_reset
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog cuts a hang short; the scenarios need well under 200 cycles, this is 2000
  initial begin
    #20us;
    error_cnt++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {srst, id_load, pri_valid, dn_valid, dn_nonposted} = 5'b10000;
    {parity_err, err_event, own_int_req, fwd_int_req} = 4'h0;
    {id_vendor_in, id_device_in} = 32'h0;
    pri_kind = SPIC_REQ_MEM;
    dn_kind = SPIC_REQ_MEM;
    repeat (3) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    t_regs();
    t_gates(16'h0000);
    t_gates(16'h0547);
    t_gates(16'h0403);
    t_reset();
    tally_and_finish();
  end
endmodule : switch_port_id_command_regs_tb_top
`default_nettype wire
